// ---- design/rgbpwm_pkg.sv ----
// ==========================================================
// shared constants for the rgb pwm block
package rgbpwm_pkg;

  // ==========================================================
  // apb register map
  localparam logic [7:0] OFS_CTRL   = 8'h00; // control
  localparam logic [7:0] OFS_STATUS = 8'h04; // status
  localparam logic [7:0] OFS_GS_A   = 8'h08; // gray value a
  localparam logic [7:0] OFS_GS_B   = 8'h0C; // gray value b
  localparam logic [7:0] OFS_GS_C   = 8'h10; // gray value c
  localparam logic [7:0] OFS_DC8    = 8'h14; // 8-bit corrections
  localparam logic [7:0] OFS_DC6    = 8'h18; // 6-bit corrections

  // field positions
  localparam int CTRL_EXT_BIT   = 0;  // external count clock select
  localparam int ST_MODE16_BIT  = 0;  // 16-bit mode active
  localparam int ST_OVF_BIT     = 1;  // sticky bit overflow
  localparam int ST_FRAMES_LSB  = 8;  // frame counter
  localparam int ST_LEVEL_LSB   = 16; // fifo level
  localparam int DC_LANE        = 8;  // lane width of packed dc

  // ==========================================================
  // serial headers and payload sizes
  localparam logic [5:0] HDR_GS16 = 6'h3F; // 16-bit gray data
  localparam logic [5:0] HDR_GS10 = 6'h2B; // 10-bit gray data
  localparam logic [5:0] HDR_DC8  = 6'h33; // 8-bit correction
  localparam logic [5:0] HDR_DC6  = 6'h27; // 6-bit correction
  localparam logic [5:0] HDR_LAST = 6'h05; // index of last header bit
  localparam logic [5:0] LEN_GS16 = 6'h30; // 3 x 16 bits
  localparam logic [5:0] LEN_GS10 = 6'h1E; // 3 x 10 bits
  localparam logic [5:0] LEN_DC8  = 6'h18; // 3 x 8 bits
  localparam logic [5:0] LEN_DC6  = 6'h12; // 3 x 6 bits

  // ==========================================================
  // correction defaults and pwm geometry
  localparam logic [7:0] DC8_DEF  = 8'hFF; // full scale 8-bit
  localparam logic [5:0] DC6_DEF  = 6'h3F; // full scale 6-bit
  localparam int         SEG_BITS = 6;     // 64 segments
  localparam int         POS_BITS = 10;    // 1024 clocks per segment
  localparam int         FIFO_DEPTH = 32;  // bit buffer depth

  // payload kind
  typedef enum logic [1:0] {
    K_GS16 = 2'h0,
    K_GS10 = 2'h1,
    K_DC8  = 2'h2,
    K_DC6  = 2'h3
  } rgbpwm_kind_e;

  // parser states, gray coded along the path
  typedef enum logic [1:0] {
    P_IDLE  = 2'h0,
    P_HDR   = 2'h1,
    P_DATA  = 2'h3,
    P_APPLY = 2'h2
  } rgbpwm_pst_e;

endpackage

// ---- design/rgbpwm_fifo.sv ----
`timescale 1ns/10ps
// ==========================================================
// synchronous fifo, valid/ready both sides
module rgbpwm_fifo #(
  parameter int W     = 1,
  parameter int DEPTH = 32
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       clk_en,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int AW = $clog2(DEPTH);

  // all fifo state
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // storage
    logic [AW-1:0]           wp;  // write pointer
    logic [AW-1:0]           rp;  // read pointer
    logic [AW:0]             cnt; // fill level
  } rgbpwm_fifo_s;

  rgbpwm_fifo_s st_r;
  rgbpwm_fifo_s st_nxt;
  logic         do_push; // accepted write
  logic         do_pop;  // accepted read

  // honest flags from the level
  assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data  = st_r.mem[st_r.rp];
  assign level     = st_r.cnt;
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  // next state
  always_comb begin
    st_nxt = st_r;
    if (do_push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp           = st_r.wp + 1'b1;
    end
    if (do_pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    // level tracks push minus pop
    if (do_push && !do_pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  // state register, frozen without enable
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end
endmodule

// ---- design/rgbpwm_chan.sv ----
`timescale 1ns/10ps
// ==========================================================
// one output channel: corrected duty and segment compare
module rgbpwm_chan
  import rgbpwm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire logic        mode16,
  input  wire logic [15:0] gray,
  input  wire logic [7:0]  dc8,
  input  wire logic [5:0]  dc6,
  input  wire logic [15:0] cnt,
  output logic             sink
);
  // channel state
  typedef struct packed {
    logic sink; // sink on
  } rgbpwm_chan_s;

  rgbpwm_chan_s st_r;
  rgbpwm_chan_s st_nxt;
  logic [24:0]  p16;  // gray x (dc8+1)
  logic [16:0]  p10;  // gray10 x (dc6+1)
  logic [15:0]  v16;  // corrected 16-bit value
  logic [9:0]   v10;  // corrected 10-bit value
  logic [10:0]  lim;  // on clocks in current segment

  assign sink = st_r.sink;

  // duty scaling and compare
  always_comb begin
    st_nxt = st_r;
    p16 = 25'(gray) * 25'({1'b0, dc8} + 9'h001);                 // R11
    v16 = p16[23:8];                                              // R11
    p10 = 17'(gray[9:0]) * 17'({1'b0, dc6} + 7'h01);             // R15
    v10 = p10[15:6];                                              // R15
    // base per segment plus one for the first remainder segments
    lim = {1'b0, v16[15:SEG_BITS]}
        + ((cnt[15:POS_BITS] < v16[SEG_BITS-1:0]) ? 11'h001 : 11'h000); // R16 R14
    if (mode16) begin
      st_nxt.sink = ({1'b0, cnt[POS_BITS-1:0]} < lim);            // R3
    end else begin
      st_nxt.sink = (cnt[POS_BITS-1:0] < v10);                    // R4
    end
  end

  // output register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end
endmodule

// ---- design/rgbpwm_top.sv ----
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
// What this block does, and what its controller sends (R10, R18)
// R1: sample serial data on serial clock fall
// R2: support 16-bit and 10-bit gray modes
// R3: 16-bit mode splits on-time over 64 segments
// R4: 10-bit mode uses one contiguous pulse
// R5: default count clock is internal tick
// R6: count clock selectable internal or external
// R7: repeat periods with held values
// R8: valid new data restarts the period
// R9: correction 8-bit or 6-bit by mode
// R10: controller sends correction before gray data
// R11: 16-bit duty gray/65536 times (dc+1)/256
// R12: 8-bit correction resets to 255
// R13: 6-bit correction resets to 63
// R14: correction keeps segmented refresh rate
// R15: 10-bit duty gray/1024 times (dc+1)/64
// R16: 64 segments of 1024, spread evenly
// R17: header check after a one bit
// R18: controller sends last device data first
module rgbpwm_top
  import rgbpwm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link pins and external count clock input
  input  wire logic        serial_clock_in,
  input  wire logic        serial_data_in,
  output logic             forwarded_data_out,
  input  wire logic        external_count_clock_in,
  // led sinks, high means on
  output logic             channel_a_sink,
  output logic             channel_b_sink,
  output logic             channel_c_sink
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0]       ck_sy;   // serial clock sync, [0] first
    logic             ck_d;    // serial clock delayed
    logic [1:0]       sd_sy;   // serial data sync, [0] first
    logic [1:0]       ex_sy;   // external count clock sync
    logic             ex_d;    // external clock delayed
    logic             fwd;     // forwarded data
    logic             ext_sel; // count clock select
    logic             ovf;     // sticky fifo overflow
    logic [7:0]       frames;  // accepted gray sets
    logic             mode16;  // 16-bit gray mode active
    rgbpwm_pst_e      pst;     // parser state
    rgbpwm_kind_e     kind;    // payload kind
    logic [5:0]       hdr;     // header shifter
    logic [5:0]       bitcnt;  // bits in field
    logic [47:0]      shreg;   // payload shifter
    logic [2:0][15:0] gs;      // gray values a,b,c
    logic [2:0][7:0]  dc8;     // 8-bit corrections
    logic [2:0][5:0]  dc6;     // 6-bit corrections
    logic [15:0]      cnt;     // pwm counter
    logic [31:0]      rdata;   // apb read data
    logic             err;     // apb error
  } rgbpwm_top_s;

  rgbpwm_top_s st_r;
  rgbpwm_top_s st_nxt;

  // fifo hookup, pwm tick, apb phases and channel sinks
  logic        fall;       // serial clock falling edge
  logic        in_ready;   // fifo has room
  logic        out_valid;  // bit waiting
  logic        out_ready;  // parser takes bit
  logic [0:0]  out_bit;    // bit at fifo head
  logic [5:0]  level;      // fifo fill
  logic        take;       // bit consumed now
  logic        tick;       // pwm count enable
  logic        setup;      // apb setup phase
  logic        wr_acc;     // apb write access
  logic [2:0]  chan_sink;  // sink per channel

  // ==========================================================
  // payload length per kind
  function automatic logic [5:0] len_of(input rgbpwm_kind_e k);
    logic [5:0] l;
    l = LEN_GS16;
    case (k)
      K_GS16: l = LEN_GS16;
      K_GS10: l = LEN_GS10;
      K_DC8:  l = LEN_DC8;
      default: l = LEN_DC6;
    endcase
    return l;
  endfunction

  // ==========================================================
  // glue
  // edge from second and delayed stages only
  assign fall      = st_r.ck_d & ~st_r.ck_sy[1];               // R1
  assign out_ready = (st_r.pst != P_APPLY);   // stall while committing
  assign take      = out_valid & out_ready;
  // internal tick every clock, external on its rising edge
  assign tick      = st_r.ext_sel ? (st_r.ex_sy[1] & ~st_r.ex_d) : 1'b1; // R5 R6
  assign setup     = psel & ~penable;
  assign wr_acc    = psel & penable & pwrite;
  assign pready    = 1'b1;  // zero wait states
  assign prdata    = st_r.rdata;
  assign pslverr   = st_r.err & psel & penable;
  assign forwarded_data_out = st_r.fwd;
  assign channel_a_sink = chan_sink[0];
  assign channel_b_sink = chan_sink[1];
  assign channel_c_sink = chan_sink[2];

  // ==========================================================
  // bit buffer between pin sampler and parser
  rgbpwm_fifo #(
    .W     (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .in_valid  (fall),
    .in_ready  (in_ready),
    .in_data   (st_r.sd_sy[1]),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_bit),
    .level     (level)
  );

  // ==========================================================
  // one compare unit per channel
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ch
      rgbpwm_chan u_chan (
        .clk    (clk),
        .srst   (srst),
        .clk_en (clk_en),
        .mode16 (st_r.mode16),
        .gray   (st_r.gs[gi]),
        .dc8    (st_r.dc8[gi]),
        .dc6    (st_r.dc6[gi]),
        .cnt    (st_r.cnt),
        .sink   (chan_sink[gi])
      );
    end
  endgenerate

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;

    // pin synchronisers
    st_nxt.ck_sy = {st_r.ck_sy[0], serial_clock_in};
    st_nxt.ck_d  = st_r.ck_sy[1];
    st_nxt.sd_sy = {st_r.sd_sy[0], serial_data_in};
    st_nxt.ex_sy = {st_r.ex_sy[0], external_count_clock_in};
    st_nxt.ex_d  = st_r.ex_sy[1];
    st_nxt.fwd   = st_r.sd_sy[1];

    // pwm counter free runs, wraps per mode
    if (tick) begin
      if (st_r.mode16) begin
        st_nxt.cnt = st_r.cnt + 16'h0001;                       // R7
      end else begin
        st_nxt.cnt = {6'h00, st_r.cnt[9:0] + 10'h001};          // R7 R4
      end
    end

    // overflow when a sampled bit finds no room
    if (fall && !in_ready) begin
      st_nxt.ovf = 1'b1;
    end

    // parser, one bit per take
    case (st_r.pst)
      P_IDLE: begin
        // a one bit opens a header
        if (take && out_bit[0]) begin
          st_nxt.hdr    = 6'h01;                                // R17
          st_nxt.bitcnt = 6'h01;
          st_nxt.pst    = P_HDR;
        end
      end
      P_HDR: begin
        if (take) begin
          st_nxt.hdr    = {st_r.hdr[4:0], out_bit[0]};
          st_nxt.bitcnt = st_r.bitcnt + 6'h01;
          if (st_r.bitcnt == HDR_LAST) begin
            st_nxt.bitcnt = 6'h00;
            st_nxt.shreg  = '0;
            st_nxt.pst    = P_DATA;
            // header decode, mismatch waits for next one
            if (st_nxt.hdr == HDR_GS16) begin                   // R17
              st_nxt.kind = K_GS16;
            end else if (st_nxt.hdr == HDR_GS10) begin
              st_nxt.kind = K_GS10;
            end else if (st_nxt.hdr == HDR_DC8) begin
              st_nxt.kind = K_DC8;
            end else if (st_nxt.hdr == HDR_DC6) begin
              st_nxt.kind = K_DC6;
            end else begin
              st_nxt.pst = P_IDLE;                              // R17
            end
          end
        end
      end
      P_DATA: begin
        // msb first, channel c then b then a
        if (take) begin
          st_nxt.shreg  = {st_r.shreg[46:0], out_bit[0]};
          st_nxt.bitcnt = st_r.bitcnt + 6'h01;
          if (st_nxt.bitcnt == len_of(st_r.kind)) begin
            st_nxt.pst = P_APPLY;
          end
        end
      end
      P_APPLY: begin
        // commit the payload
        st_nxt.pst = P_IDLE;
        case (st_r.kind)
          K_GS16: begin
            st_nxt.gs[2]  = st_r.shreg[47:32];
            st_nxt.gs[1]  = st_r.shreg[31:16];
            st_nxt.gs[0]  = st_r.shreg[15:0];
            st_nxt.mode16 = 1'b1;                               // R2
            st_nxt.cnt    = 16'h0000;                           // R8
            st_nxt.frames = st_r.frames + 8'h01;
          end
          K_GS10: begin
            st_nxt.gs[2]  = {6'h00, st_r.shreg[29:20]};
            st_nxt.gs[1]  = {6'h00, st_r.shreg[19:10]};
            st_nxt.gs[0]  = {6'h00, st_r.shreg[9:0]};
            st_nxt.mode16 = 1'b0;                               // R2
            st_nxt.cnt    = 16'h0000;                           // R8
            st_nxt.frames = st_r.frames + 8'h01;
          end
          K_DC8: begin
            st_nxt.dc8[2] = st_r.shreg[23:16];                  // R9
            st_nxt.dc8[1] = st_r.shreg[15:8];
            st_nxt.dc8[0] = st_r.shreg[7:0];
          end
          default: begin
            st_nxt.dc6[2] = st_r.shreg[17:12];                  // R9
            st_nxt.dc6[1] = st_r.shreg[11:6];
            st_nxt.dc6[0] = st_r.shreg[5:0];
          end
        endcase
      end
      default: begin
        st_nxt.pst = P_IDLE;
      end
    endcase

    // apb write at the access edge
    if (wr_acc) begin
      if (paddr == OFS_CTRL) begin
        st_nxt.ext_sel = pwdata[CTRL_EXT_BIT];                 // R6
      end else if (paddr == OFS_STATUS) begin
        // write one clears, a new overflow wins
        if (pwdata[ST_OVF_BIT] && !(fall && !in_ready)) begin
          st_nxt.ovf = 1'b0;
        end
      end
    end

    // apb read data and decode latched in setup
    if (setup) begin
      st_nxt.rdata = 32'h0000_0000;
      st_nxt.err   = 1'b0;
      if (paddr == OFS_CTRL) begin
        st_nxt.rdata[CTRL_EXT_BIT] = st_r.ext_sel;
      end else if (paddr == OFS_STATUS) begin
        st_nxt.rdata[ST_MODE16_BIT] = st_r.mode16;
        st_nxt.rdata[ST_OVF_BIT]    = st_r.ovf;
        st_nxt.rdata[ST_FRAMES_LSB +: 8] = st_r.frames;
        st_nxt.rdata[ST_LEVEL_LSB +: 6]  = level;
      end else if (paddr == OFS_GS_A) begin
        st_nxt.rdata[15:0] = st_r.gs[0];
      end else if (paddr == OFS_GS_B) begin
        st_nxt.rdata[15:0] = st_r.gs[1];
      end else if (paddr == OFS_GS_C) begin
        st_nxt.rdata[15:0] = st_r.gs[2];
      end else if (paddr == OFS_DC8) begin
        st_nxt.rdata[3*DC_LANE-1:0] = st_r.dc8;
      end else if (paddr == OFS_DC6) begin
        st_nxt.rdata[DC_LANE*0 +: 6] = st_r.dc6[0];
        st_nxt.rdata[DC_LANE*1 +: 6] = st_r.dc6[1];
        st_nxt.rdata[DC_LANE*2 +: 6] = st_r.dc6[2];
      end else begin
        st_nxt.err = 1'b1;  // unmapped
      end
    end
  end

  // ==========================================================
  // state register, frozen without enable
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r        <= '0;
      st_r.dc8    <= {3{DC8_DEF}};                              // R12
      st_r.dc6    <= {3{DC6_DEF}};                              // R13
      st_r.mode16 <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end
endmodule

// ---- verif/rgbpwm_chk_props.sv ----
`timescale 1ns/10ps
// ==========================================
// port checker for the rgb pwm block
module rgbpwm_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_data_in,
  input wire logic        forwarded_data_out,
  input wire logic        channel_a_sink,
  input wire logic        channel_b_sink,
  input wire logic        channel_c_sink
);
  logic [2:0] age_r;  // edges since reset release
  logic       mapped; // address hits the map
  logic       sinks;  // any sink on

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ==========================================
  // helpers
  assign mapped = (paddr <= 8'h18) && (paddr[1:0] == 2'h0);
  assign sinks  = channel_a_sink || channel_b_sink || channel_c_sink;
  // saturating age, keeps pipeline checks off reset leftovers
  always_ff @(posedge clk) begin
    if (srst) begin
      age_r <= 3'h0;
    end else if (age_r != 3'h7) begin
      age_r <= age_r + 3'h1;
    end
  end

  sequence acc_s;
    psel && penable;
  endsequence
  sequence rel_s;
    $fell(srst);
  endsequence

  // ==========================================
  // assertions
  pready_one_a: assert property (pready)
    else $error("pready not high");
  slverr_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error flag outside access");
  slverr_map_a: assert property (acc_s |-> pslverr == !mapped)
    else $error("error flag disagrees with map");
  prdata_hold_a: assert property (!$past(psel && !penable) |-> $stable(prdata))
    else $error("read data moved outside setup");
  fwd_copy_a: assert property (age_r > 3'h4 |-> forwarded_data_out == $past(serial_data_in, 3))
    else $error("forwarded data not a 3 cycle copy");
  rst_clear_a: assert property (@(posedge clk) disable iff (1'b0) srst |=> !sinks && !forwarded_data_out)
    else $error("outputs not cleared by reset");
  rst_apb_a: assert property (@(posedge clk) disable iff (1'b0) srst |=> prdata == 32'h0 && !pslverr)
    else $error("bus outputs not cleared by reset");
  sink_quiet_a: assert property (rel_s |-> (!sinks) [*8])
    else $error("sink on with zero gray after reset");
endmodule

bind rgbpwm_top rgbpwm_chk chk_u (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_data_in(serial_data_in),
  .forwarded_data_out(forwarded_data_out), .channel_a_sink(channel_a_sink),
  .channel_b_sink(channel_b_sink), .channel_c_sink(channel_c_sink)
);

// ---- verif/rgbpwm_ctl_mdl.sv ----
`timescale 1ns/10ps
// ==========================================
// serial controller model, one device on the chain
module rgbpwm_ctl_mdl (
  input wire logic clk,
  output logic     sclk,
  output logic     sdat
);
  // clock stands low between frames
  initial begin
    sclk = 1'b0;
    sdat = 1'b0;
  end
  // msb first, slow clock, data changes while clock is high so only the fall sees it
  task automatic send(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
      sdat <= v[i];
      repeat (3) @(posedge clk);
      sclk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    sdat <= ~sdat; // released line shows no stale level
    @(posedge clk);
  endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/10ps
// ==========================================
// bench for the rgb pwm block
module tb;
  import rgbpwm_pkg::*;
  logic        clk = 1'b0;     // 10 mhz
  logic        srst = 1'b1;    // sync reset
  logic        clk_en = 1'b1;  // clock enable
  logic        psel = 1'b0;    // apb select
  logic        penable = 1'b0; // apb enable
  logic        pwrite = 1'b0;  // apb direction
  logic [7:0]  paddr = 8'h00;  // apb address
  logic [31:0] pwdata = 32'h0; // apb write data
  logic [31:0] prdata;         // apb read data
  logic        pready, pslverr, fwd, sclk, sdat, sa, sb, sc;
  logic        ext_clk = 1'b0; // external count clock
  logic        ext_run = 1'b0; // external clock running
  logic [1:0]  ext_div = 2'h0; // divider for it
  logic [31:0] r;              // last read data
  logic        e;              // last read error
  int          err_count = 0;
  int          tests_run = 0;
  int          hi [3];         // high cycles per sink
  int          rs [3];         // rising edges per sink
  int          n;              // wait counter

  always #50 clk = ~clk;
  // external clock, period of 8 cycles, only while running
  always @(posedge clk) begin
    if (ext_run) begin
      ext_div <= ext_div + 2'h1;
      if (ext_div == 2'h3) ext_clk <= ~ext_clk;
    end
  end

  rgbpwm_top dut_u (
    .clk(clk), .srst(srst), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_in(sclk), .serial_data_in(sdat), .forwarded_data_out(fwd),
    .external_count_clock_in(ext_clk), .channel_a_sink(sa), .channel_b_sink(sb), .channel_c_sink(sc)
  );
  rgbpwm_ctl_mdl mdl_u (.clk(clk), .sclk(sclk), .sdat(sdat));

  // ==========================================
  // tasks
  task automatic give_verdict();
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready, one idle cycle after
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  // header then payload, payload left aligned
  task automatic frame(input logic [5:0] h, input logic [47:0] p, input int nb);
    mdl_u.send(64'({h, p}) >> (48 - nb), 6 + nb);
    repeat (20) @(posedge clk);
  endtask
  // counts high cycles and rises of every sink over c cycles
  task automatic meas(input int c);
    logic [2:0] s, p;
    hi = '{0, 0, 0};
    rs = '{0, 0, 0};
    p = {sc, sb, sa};
    repeat (c) begin
      @(posedge clk);
      s = {sc, sb, sa};
      for (int k = 0; k < 3; k++) begin
        hi[k] += int'(s[k]);
        rs[k] += int'(s[k] & ~p[k]);
      end
      p = s;
    end
  endtask
  task automatic chk3(input int a, input int b, input int c, input int rr);
    chk(hi[0], a);
    chk(hi[1], b);
    chk(hi[2], c);
    for (int k = 0; k < 3; k++) chk(rs[k], rr);
  endtask

  // ==========================================
  // watchdog
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_DC8, 32'h00FFFFFF);
    rd(OFS_DC6, 32'h003F3F3F);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, OFS_GS_A, 32'h1234);
    rd(OFS_GS_A, 32'h0);
    // bad header first, then a good 16-bit set
    mdl_u.send(64'(6'h20), 6);
    frame(HDR_GS16, {16'h4000, 16'h0100, 16'h8000}, 48);
    rd(OFS_GS_A, 32'h8000);
    rd(OFS_GS_B, 32'h0100);
    rd(OFS_GS_C, 32'h4000);
    rd(OFS_STATUS, 32'h101);
    meas(4096);
    chk3(2048, 16, 1024, 4);
    // correction first, then gray
    frame(HDR_DC8, {8'hFF, 8'hFF, 8'h7F, 24'h0}, 24);
    rd(OFS_DC8, 32'h00FFFF7F);
    frame(HDR_GS16, {16'h4000, 16'h0100, 16'h8000}, 48);
    meas(4096);
    chk3(1024, 16, 1024, 4);
    // 10-bit set restarts the period at once
    frame(HDR_GS10, {10'h100, 10'h3FF, 10'h200, 18'h0}, 30);
    n = 0;
    while (sa === 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= 490 && n <= 510}, 32'h1);
    meas(2048);
    chk3(1024, 2046, 512, 2);
    rd(OFS_STATUS, 32'h300);
    frame(HDR_DC6, {6'h3F, 6'h3F, 6'h0F, 30'h0}, 18);
    rd(OFS_DC6, 32'h003F3F0F);
    frame(HDR_GS10, {10'h100, 10'h3FF, 10'h200, 18'h0}, 30);
    meas(2048);
    chk3(256, 2046, 512, 2);
    // clock enable low freezes the running pattern
    clk_en <= 1'b0;
    @(posedge clk);
    meas(2000);
    chk(rs[0] + rs[1] + rs[2], 0);
    clk_en <= 1'b1;
    // external count clock
    apb(1'b1, OFS_CTRL, 32'h1);
    rd(OFS_CTRL, 32'h1);
    ext_run <= 1'b1;
    repeat (64) @(posedge clk);
    meas(8192);
    chk3(1024, 8184, 2048, 1);
    ext_run <= 1'b0;
    repeat (16) @(posedge clk);
    meas(2000);
    chk(rs[0] + rs[1] + rs[2], 0);
    apb(1'b1, OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h400);
    give_verdict();
  end
endmodule
